// ---- dspo_pkg.sv ----
// Constants shared by the dual sample pipeline output block
// Notes on behaviour
// - Each of the two channels yields a 12-bit word for its input sample.
// - Each channel delivers one word on every clock, so word rate is clock rate.
// - Both channels take their samples on the same rising clock edge.
// - A sample's word appears seven cycles after its edge, alike on both sides.
// - Words are coded as offset binary or two's complement, as selected.
// - Zero input gives 800 offset binary or 000 two's complement (MSB flipped).
// - Negative full scale gives 000 or 800, positive full scale fff or 7ff.
// - Quarter scale negative gives 400 or c00, quarter positive c00 or 400.
// - Inputs past full scale saturate at the extreme codes and never wrap.
// - A high sleep request holds the converter in its low-power state.
// - Format select low gives offset binary and high gives two's complement.
// - While asleep the words are forced to 000 and pipeline contents are lost.
package dspo_pkg;
  // ****************************************************
  // Word layout and timing
  // ****************************************************
  localparam int CODE_W = 12;
  localparam int LATENCY = 7;
  localparam int CHANNELS = 2;
  localparam int IN_W_DEF = 14;
  localparam int CLK_MHZ = 100;
  localparam int RATE_MIN_MSPS = 10;
  localparam int RATE_MAX_MSPS = 80;
  localparam int FILL_W = 4;
  localparam logic [FILL_W-1:0] FILL_ZERO = 4'h0;
  localparam logic [FILL_W-1:0] FILL_DONE = 4'(LATENCY);

  // ****************************************************
  // Coding
  // ****************************************************
  localparam logic FMT_OFFSET = 1'b0;
  localparam logic FMT_TWOS = 1'b1;
  localparam int CODE_MAX = 2047;
  localparam int CODE_MIN = -2048;
  localparam int QUARTER_POS = 1024;
  localparam int QUARTER_NEG = -1024;
  localparam logic [CODE_W-1:0] WORD_RESET = 12'h000;
  localparam logic [CODE_W-1:0] MSB_FLIP = 12'h800;
  localparam logic [CODE_W-1:0] TC_POS_FS = 12'h7ff;
  localparam logic [CODE_W-1:0] TC_NEG_FS = 12'h800;
  localparam logic [CODE_W-1:0] OB_MID = 12'h800;
  localparam logic [CODE_W-1:0] TC_MID = 12'h000;
  localparam logic [CODE_W-1:0] OB_POS_FS = 12'hfff;
  localparam logic [CODE_W-1:0] OB_NEG_FS = 12'h000;
  localparam logic [CODE_W-1:0] OB_Q_NEG = 12'h400;
  localparam logic [CODE_W-1:0] TC_Q_NEG = 12'hc00;
  localparam logic [CODE_W-1:0] OB_Q_POS = 12'hc00;
  localparam logic [CODE_W-1:0] TC_Q_POS = 12'h400;
endpackage : dspo_pkg

// ---- dspo_channel.sv ----
// One conversion channel: saturating quantiser and fixed-latency pipeline
`timescale 1ns/1ps
module dspo_channel #(
  parameter int IN_W = dspo_pkg::IN_W_DEF,
  parameter int LAT = dspo_pkg::LATENCY
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic signed [IN_W-1:0] sample_in,
  input wire logic code_format_select_in,
  input wire logic sleep_in,
  output logic [dspo_pkg::CODE_W-1:0] word_out
);
  // ****************************************************
  // Pipeline state
  // ****************************************************
  logic [dspo_pkg::CODE_W-1:0] stage [LAT];
  logic [dspo_pkg::CODE_W-1:0] next_stage [LAT];
  logic [dspo_pkg::CODE_W-1:0] next_word;
  logic [dspo_pkg::CODE_W-1:0] clamped;

  // Quantise to two's complement, clipping rather than wrapping
  always_comb begin
    if (sample_in > dspo_pkg::CODE_MAX) begin
      clamped = dspo_pkg::TC_POS_FS;
    end else if (sample_in < dspo_pkg::CODE_MIN) begin
      clamped = dspo_pkg::TC_NEG_FS;
    end else begin
      clamped = sample_in[dspo_pkg::CODE_W-1:0];
    end
  end

  // Shift one sample per clock; sleep flushes the stages
  always_comb begin
    for (int i = 0; i < LAT; i++) begin
      if (sleep_in) begin
        next_stage[i] = dspo_pkg::WORD_RESET;
      end else if (i == 0) begin
        next_stage[i] = clamped;
      end else begin
        next_stage[i] = stage[i-1];
      end
    end
    // Coding is applied last so a format change needs no flush
    if (sleep_in) begin
      next_word = dspo_pkg::WORD_RESET;
    end else if (code_format_select_in == dspo_pkg::FMT_TWOS) begin
      next_word = stage[LAT-1];
    end else begin
      next_word = stage[LAT-1] ^ dspo_pkg::MSB_FLIP;
    end
  end

  // Registers only; the word leaves seven edges after capture
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < LAT; i++) begin
        stage[i] <= dspo_pkg::WORD_RESET;
      end
      word_out <= dspo_pkg::WORD_RESET;
    end else begin
      stage <= next_stage;
      word_out <= next_word;
    end
  end
endmodule : dspo_channel

// ---- dspo_top.sv ----
// Dual sample pipeline output: two channels, sleep control and checks
`timescale 1ns/1ps
module dspo_top #(
  parameter int IN_W = dspo_pkg::IN_W_DEF
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic signed [IN_W-1:0] sample_a_in,
  input wire logic signed [IN_W-1:0] sample_b_in,
  input wire logic code_format_select_in,
  input wire logic sleep_request_in,
  output logic [dspo_pkg::CODE_W-1:0] word_a_out,
  output logic [dspo_pkg::CODE_W-1:0] word_b_out,
  output logic low_power_out,
  output logic words_valid_out
);
  // ****************************************************
  // Channels
  // ****************************************************
  logic signed [IN_W-1:0] sample_arr [dspo_pkg::CHANNELS];
  logic [dspo_pkg::CODE_W-1:0] word_arr [dspo_pkg::CHANNELS];

  // Both channels see the same edge and the same controls
  assign sample_arr[0] = sample_a_in;
  assign sample_arr[1] = sample_b_in;
  assign word_a_out = word_arr[0];
  assign word_b_out = word_arr[1];

  for (genvar ch = 0; ch < dspo_pkg::CHANNELS; ch++) begin : g_chan
    dspo_channel #(
      .IN_W(IN_W),
      .LAT(dspo_pkg::LATENCY)
    ) u_chan (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .sample_in(sample_arr[ch]),
      .code_format_select_in(code_format_select_in),
      .sleep_in(sleep_request_in),
      .word_out(word_arr[ch])
    );
  end

  // ****************************************************
  // Sleep state and refill tracking
  // ****************************************************
  logic [dspo_pkg::FILL_W-1:0] fill;
  logic [dspo_pkg::FILL_W-1:0] next_fill;
  logic next_low_power;
  logic next_valid;

  // Valid only once a whole pipeline of fresh samples has passed, since
  // sleeping discards what was in flight
  always_comb begin
    next_low_power = sleep_request_in;
    next_fill = fill;
    next_valid = 1'b0;
    if (sleep_request_in) begin
      next_fill = dspo_pkg::FILL_ZERO;
    end else begin
      if (fill != dspo_pkg::FILL_DONE) begin
        next_fill = fill + 4'h1;
      end
      next_valid = (fill == dspo_pkg::FILL_DONE);
    end
  end

  // Registers for sleep and refill state
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      fill <= dspo_pkg::FILL_ZERO;
      low_power_out <= 1'b0;
      words_valid_out <= 1'b0;
    end else begin
      fill <= next_fill;
      low_power_out <= next_low_power;
      words_valid_out <= next_valid;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  // Reference coding of one sample, used only by the checks below
  function automatic logic [dspo_pkg::CODE_W-1:0] dspo_expect(
    input logic signed [IN_W-1:0] s,
    input logic f
  );
    logic [dspo_pkg::CODE_W-1:0] tc;
    tc = s[dspo_pkg::CODE_W-1:0];
    if (s > dspo_pkg::CODE_MAX) begin
      tc = dspo_pkg::TC_POS_FS;
    end else if (s < dspo_pkg::CODE_MIN) begin
      tc = dspo_pkg::TC_NEG_FS;
    end
    return (f == dspo_pkg::FMT_TWOS) ? tc : (tc ^ dspo_pkg::MSB_FLIP);
  endfunction : dspo_expect

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence seq_awake8;
    (!sleep_request_in) [*8];
  endsequence

  sequence seq_refill;
    (!words_valid_out) [*8];
  endsequence

  chk_latency_a: assert property (
    words_valid_out |->
      word_a_out == dspo_expect($past(sample_a_in, 8),
                                $past(code_format_select_in)))
    else $error("channel a word does not match sample of eight edges back");

  chk_latency_b: assert property (
    words_valid_out |->
      word_b_out == dspo_expect($past(sample_b_in, 8),
                                $past(code_format_select_in)))
    else $error("channel b word does not match sample of eight edges back");

  chk_pair_aligned: assert property (
    (words_valid_out && $past(sample_a_in, 8) == $past(sample_b_in, 8))
      |-> word_a_out == word_b_out)
    else $error("equal samples gave different words on the two channels");

  chk_midscale_code: assert property (
    (words_valid_out && $past(sample_a_in, 8) == 0) |->
      word_a_out == ($past(code_format_select_in) ? dspo_pkg::TC_MID
                                                  : dspo_pkg::OB_MID))
    else $error("zero input did not give the mid-scale code");

  chk_full_scale: assert property (
    (words_valid_out && $past(sample_a_in, 8) <= dspo_pkg::CODE_MIN) |->
      word_a_out == ($past(code_format_select_in) ? dspo_pkg::TC_NEG_FS
                                                  : dspo_pkg::OB_NEG_FS))
    else $error("negative full scale or beyond did not give the low code");

  chk_saturate_hi: assert property (
    (words_valid_out && $past(sample_b_in, 8) >= dspo_pkg::CODE_MAX) |->
      word_b_out == ($past(code_format_select_in) ? dspo_pkg::TC_POS_FS
                                                  : dspo_pkg::OB_POS_FS))
    else $error("positive overrange wrapped instead of saturating");

  chk_quarter_neg: assert property (
    (words_valid_out && $past(sample_a_in, 8) == dspo_pkg::QUARTER_NEG) |->
      word_a_out == ($past(code_format_select_in) ? dspo_pkg::TC_Q_NEG
                                                  : dspo_pkg::OB_Q_NEG))
    else $error("negative quarter scale gave the wrong code");

  chk_quarter_pos: assert property (
    (words_valid_out && $past(sample_b_in, 8) == dspo_pkg::QUARTER_POS) |->
      word_b_out == ($past(code_format_select_in) ? dspo_pkg::TC_Q_POS
                                                  : dspo_pkg::OB_Q_POS))
    else $error("positive quarter scale gave the wrong code");

  chk_sleep_state: assert property (
    sleep_request_in |=> (low_power_out && !words_valid_out
                          && word_a_out == dspo_pkg::WORD_RESET))
    else $error("sleep request did not enter the low-power state");

  chk_wake_refill: assert property (
    $fell(sleep_request_in) |-> seq_refill)
    else $error("words marked valid before the pipeline refilled");

  chk_refill_done: assert property (
    seq_awake8 |=> words_valid_out)
    else $error("words not valid after eight awake edges");

  chk_wake_state: assert property (
    $fell(sleep_request_in) |=> !low_power_out)
    else $error("low-power state held after sleep request was released");

  // ****************************************************
  // Wake, hold and sign checks
  // ****************************************************
  // One sleep edge followed by a full pipeline of awake edges
  sequence seq_wake;
    sleep_request_in ##1 seq_awake8;
  endsequence

  chk_wake_valid: assert property (
    seq_wake |=> words_valid_out)
    else $error("words not valid after a full awake pipeline");

  // The first word marked valid after waking must be the fresh sample
  chk_wake_word_a: assert property (
    seq_wake |=>
      word_a_out == dspo_expect($past(sample_a_in, 8),
                                $past(code_format_select_in)))
    else $error("first channel a word after waking is wrong");

  chk_wake_word_b: assert property (
    seq_wake |=>
      word_b_out == dspo_expect($past(sample_b_in, 8),
                                $past(code_format_select_in)))
    else $error("first channel b word after waking is wrong");

  chk_sleep_word_b: assert property (
    sleep_request_in |=> word_b_out == dspo_pkg::WORD_RESET)
    else $error("channel b word not forced during sleep");

  chk_power_low: assert property (
    !sleep_request_in |=> !low_power_out)
    else $error("low-power state entered without a sleep request");

  chk_valid_stays: assert property (
    (words_valid_out && !sleep_request_in) |=> words_valid_out)
    else $error("valid words stopped while awake");

  chk_fill_bound: assert property (
    fill <= dspo_pkg::FILL_DONE)
    else $error("refill count ran past the pipeline depth");

  // The MSB carries the sign in either coding, inverted in offset binary;
  // checked on every valid word, not only at the table points
  chk_sign_bit_a: assert property (
    words_valid_out |->
      word_a_out[dspo_pkg::CODE_W-1] == (($past(sample_a_in, 8) < 0)
                                         ^ !$past(code_format_select_in)))
    else $error("channel a sign bit does not follow the coding");

  chk_sign_bit_b: assert property (
    words_valid_out |->
      word_b_out[dspo_pkg::CODE_W-1] == (($past(sample_b_in, 8) < 0)
                                         ^ !$past(code_format_select_in)))
    else $error("channel b sign bit does not follow the coding");
endmodule : dspo_top

// ---- dspo_capture.sv ----
// Capture-side model of the logic that receives both sample words
`timescale 1ns/1ps
module dspo_capture (
  input wire logic clk_in,
  input wire logic code_format_select_in,
  input wire logic low_power_in,
  input wire logic [dspo_pkg::CODE_W-1:0] word_a_in,
  input wire logic [dspo_pkg::CODE_W-1:0] word_b_in,
  output logic signed [dspo_pkg::CODE_W-1:0] value_a_out,
  output logic signed [dspo_pkg::CODE_W-1:0] value_b_out,
  output logic usable_out
);
  // Words still to drop after a wake: seven flushed words plus the one
  // still held in our own capture register; starts full, nothing resets it
  logic [3:0] skip = 4'h8;
  logic [dspo_pkg::CODE_W-1:0] msb_fix;

  // Offset binary is brought to two's complement by flipping the MSB
  assign msb_fix = code_format_select_in ? 12'h000 : 12'h800;

  // Both words on one edge, so pairs never drift apart
  always @(posedge clk_in) begin
    value_a_out <= word_a_in ^ msb_fix;
    value_b_out <= word_b_in ^ msb_fix;
    if (low_power_in) begin
      skip <= 4'h8;
    end else if (skip != 4'h0) begin
      skip <= skip - 4'h1;
    end
  end

  assign usable_out = (skip == 4'h0);
endmodule : dspo_capture

// ---- dspo_top_bench.sv ----
// Self-checking bench for the dual sample pipeline output block
`timescale 1ns/1ps
module dspo_top_bench;
  logic clk_in, rst_b_in, code_format_select_in, sleep_request_in;
  logic signed [13:0] sample_a_in, sample_b_in;
  logic [dspo_pkg::CODE_W-1:0] word_a_out, word_b_out;
  logic low_power_out, words_valid_out, usable;
  logic signed [dspo_pkg::CODE_W-1:0] value_a, value_b;
  int error_cnt = 0;
  int samples_checked = 0;
  // Zero, both full scales, both quarter scales, two overrange, odd value
  int tbl[8] = '{0, -2048, 2047, -1024, 1024, 8191, -8192, 300};

  dspo_top #(.IN_W(14)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .sample_a_in(sample_a_in), .sample_b_in(sample_b_in),
    .code_format_select_in(code_format_select_in),
    .sleep_request_in(sleep_request_in), .word_a_out(word_a_out),
    .word_b_out(word_b_out), .low_power_out(low_power_out),
    .words_valid_out(words_valid_out));

  dspo_capture i_cap (.clk_in(clk_in),
    .code_format_select_in(code_format_select_in),
    .low_power_in(low_power_out), .word_a_in(word_a_out),
    .word_b_in(word_b_out), .value_a_out(value_a),
    .value_b_out(value_b), .usable_out(usable));

  // ****************************************************
  // Helpers
  // ****************************************************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Clip, keep low bits, flip the MSB for offset binary
  function automatic logic [11:0] code_of(input int x, input logic fmt);
    int c;
    c = x > dspo_pkg::CODE_MAX ? dspo_pkg::CODE_MAX : x;
    c = c < dspo_pkg::CODE_MIN ? dspo_pkg::CODE_MIN : c;
    return 12'(c) ^ (fmt ? 12'h000 : 12'h800);
  endfunction : code_of

  task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  // Bounded wait for valid; a timeout ends the run, the count is checked
  // by the caller
  task automatic wait_valid(output int n);
    n = 0;
    while (words_valid_out !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    if (words_valid_out !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %0t valid never rose", $time);
      tally_and_finish();
    end
  endtask : wait_valid

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic run_reset();
    int n;
    rst_b_in = 1'b0;
    repeat (20) @(negedge clk_in);
    cmp_word(word_a_out, 12'h000);
    cmp_bit(words_valid_out, 1'b0);
    rst_b_in = 1'b1;
    @(negedge clk_in);
    wait_valid(n);
    cmp_word(12'(n), 12'h007);
    $display("test reset done");
  endtask : run_reset

  // Back-to-back stream, a new word every cycle, checked 8 negedges later
  task automatic run_codes(input logic fmt);
    logic [11:0] ea[$];
    logic [11:0] eb[$];
    code_format_select_in = fmt;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_in);
      if (i >= 8) begin
        cmp_word(word_a_out, ea.pop_front());
        cmp_word(word_b_out, eb.pop_front());
      end
      if (i < 8) begin
        sample_a_in = 14'(tbl[i]);
        sample_b_in = 14'(tbl[7-i]);
        ea.push_back(code_of(tbl[i], fmt));
        eb.push_back(code_of(tbl[7-i], fmt));
      end
    end
    @(negedge clk_in);
    cmp_word(value_a, 12'h12c);
    cmp_word(value_b, 12'h000);
    $display("test codes fmt %b done", fmt);
  endtask : run_codes

  task automatic run_sleep();
    int n;
    sleep_request_in = 1'b1;
    repeat (3) @(negedge clk_in);
    cmp_bit(low_power_out, 1'b1);
    cmp_bit(words_valid_out, 1'b0);
    cmp_word(word_a_out, 12'h000);
    cmp_word(word_b_out, 12'h000);
    cmp_bit(usable, 1'b0);
    sleep_request_in = 1'b0;
    @(negedge clk_in);
    cmp_bit(low_power_out, 1'b0);
    wait_valid(n);
    cmp_word(12'(n), 12'h007);
    cmp_bit(usable, 1'b0);
    @(negedge clk_in);
    cmp_bit(usable, 1'b1);
    cmp_word(value_a, 12'h12c);
    $display("test sleep done");
  endtask : run_sleep

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    rst_b_in = 1'b0;
    code_format_select_in = 1'b0;
    sleep_request_in = 1'b0;
    sample_a_in = 14'h0000;
    sample_b_in = 14'h0000;
    run_reset();
    run_codes(1'b0);
    run_codes(1'b1);
    run_sleep();
    run_codes(1'b0);
    tally_and_finish();
  end
endmodule : dspo_top_bench
